// file: bench/host_spi_model.sv
// Host side model that drives 16-bit serial frames and collects the status answer
`timescale 1ns/10ps
module host_spi_model (
  // Clock
  input  wire logic i_clk,
  // Serial pins
  output logic      o_spi_sclk,
  output logic      o_spi_cs_n,
  output logic      o_spi_mosi,
  input  wire logic i_spi_miso
);
  localparam int PHASE = 4;  // Cycles per serial clock phase, above the synchroniser need

  // Idle pins from time zero
  initial begin
    o_spi_sclk = 1'b0;
    o_spi_cs_n = 1'b1;
    o_spi_mosi = 1'b0;
  end

  // One frame, MSB first; a bit count other than 16 gives a frame the device drops
  task automatic xfer(input logic [15:0] word, input int nbits, output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    @(negedge i_clk);
    o_spi_cs_n = 1'b0;
    repeat (PHASE) @(negedge i_clk);
    for (i = 0; i < nbits; i++) begin
      o_spi_mosi = word[15-i];
      repeat (PHASE) @(negedge i_clk);
      o_spi_sclk = 1'b1;
      rx = {rx[14:0], i_spi_miso};
      repeat (PHASE) @(negedge i_clk);
      o_spi_sclk = 1'b0;
    end
    repeat (PHASE) @(negedge i_clk);
    o_spi_cs_n = 1'b1;
    // Released data line shows no stale value
    o_spi_mosi = ~o_spi_mosi;
    // Room for the frame to act before the caller looks
    repeat (2 * PHASE) @(negedge i_clk);
  endtask
endmodule

// file: bench/tb_operating_mode_state_machine.sv
// Self-checking bench for the operating-mode controller
`timescale 1ns/10ps
`include "opmode_params.svh"
module tb_operating_mode_state_machine;
  import opmode_pkg::*;
  localparam int WIN = 4000;  // Shortened long watchdog window in cycles
  localparam int RD  = 1250;  // Restart delay in cycles
  // Design pins
  logic        i_clk, i_sys_rst, i_spi_sclk, i_spi_cs_n, i_spi_mosi, o_spi_miso;
  logic        i_can_wake, i_main_regulator_uv, i_over_temp, i_test_strap_n, i_cfg_strap;
  logic [0:0]  i_lin_transceivers_wake, i_wake_inputs;
  logic        o_main_regulator_output_en, o_host_reset_n, o_dev_mode, o_wd_fail_restart, o_wd_running;
  mode_state_e o_mode;
  // Bench state
  logic [15:0] rx;
  int          failures = 0;
  int          n_tests  = 0;
  int          s;

  // Clock
  initial i_clk = 1'b0;
  always #(`CLK_PERIOD_NS / 2) i_clk = ~i_clk;

  // Block under test
  operating_mode_state_machine #(.LONG_WINDOW_CYCLES(WIN)) operating_mode_state_machine_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_spi_sclk(i_spi_sclk), .i_spi_cs_n(i_spi_cs_n), .i_spi_mosi(i_spi_mosi), .o_spi_miso(o_spi_miso),
    .i_can_wake(i_can_wake), .i_lin_transceivers_wake(i_lin_transceivers_wake), .i_wake_inputs(i_wake_inputs),
    .i_main_regulator_uv(i_main_regulator_uv), .i_over_temp(i_over_temp),
    .i_test_strap_n(i_test_strap_n), .i_cfg_strap(i_cfg_strap),
    .o_main_regulator_output_en(o_main_regulator_output_en), .o_host_reset_n(o_host_reset_n),
    .o_mode(o_mode), .o_dev_mode(o_dev_mode), .o_wd_fail_restart(o_wd_fail_restart),
    .o_wd_running(o_wd_running));

  // Host microcontroller model
  host_spi_model host_spi_model_i (
    .i_clk(i_clk), .o_spi_sclk(i_spi_sclk), .o_spi_cs_n(i_spi_cs_n), .o_spi_mosi(i_spi_mosi),
    .i_spi_miso(o_spi_miso));

  // Compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic complete_run;
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Wait for a mode under a bound, then compare it
  task automatic wait_mode(input mode_state_e m, input int lim);
    int n;
    n = 0;
    while (o_mode !== m && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    check("mode", 16'(o_mode), 16'(m));
  endtask

  // Reset with chosen straps, held six cycles
  task automatic do_reset(input logic cfg, input logic test_n);
    @(negedge i_clk);
    i_sys_rst = 1'b1;
    i_cfg_strap = cfg;
    i_test_strap_n = test_n;
    repeat (6) @(negedge i_clk);
    i_sys_rst = 1'b0;
    repeat (6) @(negedge i_clk);
  endtask

  // Wake levels: can, lin, wake inputs
  task automatic set_wake(input logic [2:0] v);
    {i_can_wake, i_lin_transceivers_wake, i_wake_inputs} = v;
  endtask

  // Watchdog trigger frame
  task automatic kick;
    host_spi_model_i.xfer({1'b1, `ADDR_WD_CTRL, 8'h00}, 16, rx);
  endtask

  // Mode field write frame
  task automatic mode_frame(input mode_field_e f);
    host_spi_model_i.xfer({1'b1, `ADDR_MODE_CTRL, f, 6'h00}, 16, rx);
  endtask

  // Power-up state, discarded wakes, short frame, any frame leaves init
  task automatic t_init;
    do_reset(1'b1, 1'b1);
    check("mode", 16'(o_mode), 16'(ST_INIT));
    check("reg_en", 16'(o_main_regulator_output_en), 16'h0001);
    check("host_rst_n", 16'(o_host_reset_n), 16'h0001);
    check("cfg", 16'(o_wd_fail_restart), 16'h0001);
    check("dev", 16'(o_dev_mode), 16'h0000);
    set_wake(3'b111);
    repeat (20) @(negedge i_clk);
    set_wake(3'b000);
    check("mode", 16'(o_mode), 16'(ST_INIT));
    host_spi_model_i.xfer(16'h7fff, 15, rx);
    check("mode", 16'(o_mode), 16'(ST_INIT));
    host_spi_model_i.xfer(16'h7fff, 16, rx);
    check("status", rx, 16'h0300);
    wait_mode(ST_NORMAL, 10);
  endtask

  // Stop and sleep levels, each wake source, restart delay, field cleared
  task automatic t_modes;
    kick;
    mode_frame(FIELD_STOP);
    wait_mode(ST_STOP, 10);
    check("reg_en", 16'(o_main_regulator_output_en), 16'h0001);
    mode_frame(FIELD_NORMAL);
    check("status", 16'(rx[15:9]), 16'h0035);
    wait_mode(ST_NORMAL, 10);
    for (s = 0; s < 3; s++) begin
      mode_frame(FIELD_SLEEP);
      wait_mode(ST_SLEEP, 10);
      check("reg_en", 16'(o_main_regulator_output_en), 16'h0000);
      set_wake(3'b100 >> s);
      wait_mode(ST_RESTART, 10);
      check("host_rst_n", 16'(o_host_reset_n), 16'h0000);
      set_wake(3'b000);
      repeat (RD - 50) @(negedge i_clk);
      check("mode", 16'(o_mode), 16'(ST_RESTART));
      wait_mode(ST_NORMAL, 100);
      kick;
      check("status", 16'(rx[15:9]), 16'h0011);
    end
    mode_frame(FIELD_SOFT_RESET);
    wait_mode(ST_INIT, 10);
  endtask

  // Missed trigger in init and in stop or normal, strap picks the response
  task automatic t_wd(input logic cfg);
    do_reset(cfg, 1'b1);
    wait_mode(ST_RESTART, WIN + 100);
    wait_mode(ST_NORMAL, RD + 100);
    kick;
    if (cfg) begin
      mode_frame(FIELD_STOP);
    end
    repeat (WIN - 400) @(negedge i_clk);
    check("mode", 16'(o_mode), 16'(cfg ? ST_STOP : ST_NORMAL));
    wait_mode(cfg ? ST_RESTART : ST_FAILSAFE, 500);
    check("reg_en", 16'(o_main_regulator_output_en), 16'(cfg));
    check("host_rst_n", 16'(o_host_reset_n), 16'h0000);
    if (!cfg) begin
      repeat (100) @(negedge i_clk);
      check("mode", 16'(o_mode), 16'(ST_FAILSAFE));
      set_wake(3'b010);
      wait_mode(ST_RESTART, 10);
      set_wake(3'b000);
    end
    wait_mode(ST_NORMAL, RD + 100);
  endtask

  // Undervoltage holds restart; heat holds fail-safe until it clears
  task automatic t_uv_heat;
    kick;
    i_main_regulator_uv = 1'b1;
    wait_mode(ST_RESTART, 10);
    repeat (RD + 200) @(negedge i_clk);
    check("mode", 16'(o_mode), 16'(ST_RESTART));
    i_main_regulator_uv = 1'b0;
    repeat (RD - 50) @(negedge i_clk);
    check("mode", 16'(o_mode), 16'(ST_RESTART));
    wait_mode(ST_NORMAL, 100);
    kick;
    i_over_temp = 1'b1;
    wait_mode(ST_FAILSAFE, 10);
    check("reg_en", 16'(o_main_regulator_output_en), 16'h0000);
    repeat (200) @(negedge i_clk);
    check("mode", 16'(o_mode), 16'(ST_FAILSAFE));
    i_over_temp = 1'b0;
    wait_mode(ST_RESTART, 10);
    wait_mode(ST_NORMAL, RD + 100);
  endtask

  // Development strap: watchdog stopped, all six modes reachable
  task automatic t_dev;
    do_reset(1'b1, 1'b0);
    check("dev", 16'(o_dev_mode), 16'h0001);
    check("wd_run", 16'(o_wd_running), 16'h0000);
    repeat (WIN + 200) @(negedge i_clk);
    check("mode", 16'(o_mode), 16'(ST_INIT));
    mode_frame(FIELD_STOP);
    wait_mode(ST_NORMAL, 10);
    mode_frame(FIELD_STOP);
    wait_mode(ST_STOP, 10);
    repeat (WIN + 200) @(negedge i_clk);
    check("mode", 16'(o_mode), 16'(ST_STOP));
    mode_frame(FIELD_SLEEP);
    wait_mode(ST_SLEEP, 10);
    set_wake(3'b001);
    wait_mode(ST_RESTART, 10);
    set_wake(3'b000);
    i_over_temp = 1'b1;
    wait_mode(ST_FAILSAFE, 10);
    i_over_temp = 1'b0;
    wait_mode(ST_RESTART, 10);
    wait_mode(ST_NORMAL, RD + 100);
    mode_frame(FIELD_SOFT_RESET);
    wait_mode(ST_INIT, 10);
  endtask

  // Main sequence
  initial begin
    i_sys_rst = 1'b1;
    i_test_strap_n = 1'b1;
    {i_can_wake, i_lin_transceivers_wake, i_wake_inputs, i_main_regulator_uv, i_over_temp, i_cfg_strap} = '0;
    t_init;
    t_modes;
    t_wd(1'b1);
    t_uv_heat;
    t_wd(1'b0);
    t_dev;
    complete_run;
  end

  // Hang guard, more than twice the expected run
  initial begin
    repeat (100000) @(posedge i_clk);
    failures++;
    complete_run;
  end
endmodule

// file: shared/opmode_params.svh
// Constants for the operating-mode controller
`ifndef OPMODE_PARAMS_SVH
`define OPMODE_PARAMS_SVH
// Serial frame layout
`define FRAME_BITS       16
`define WRITE_BIT        15
`define ADDR_MSB         14
`define ADDR_LSB         8
`define MODE_FIELD_MSB   7
`define MODE_FIELD_LSB   6
// Frame addresses
`define ADDR_MODE_CTRL   7'h01
`define ADDR_WD_CTRL     7'h03
// Reset value of the operating-mode field
`define MODE_FIELD_RESET 2'h0
// Clock rate
`define CLK_PERIOD_NS    8
`define CLK_MHZ          125
// Timing figures in their own units
`define RESTART_DELAY_US 10
`define LONG_WINDOW_MS   200
`endif

// file: shared/opmode_pkg.sv
// Types shared by the operating-mode controller
package opmode_pkg;
  // Operating modes, Gray coded along init-normal-stop-sleep-restart-failsafe
  typedef enum logic [2:0] {
    ST_INIT     = 3'h0,
    ST_NORMAL   = 3'h1,
    ST_STOP     = 3'h3,
    ST_SLEEP    = 3'h2,
    ST_RESTART  = 3'h6,
    ST_FAILSAFE = 3'h7
  } mode_state_e;
  // Values of the operating-mode field in a mode frame
  typedef enum logic [1:0] {
    FIELD_NORMAL     = 2'h0,
    FIELD_STOP       = 2'h1,
    FIELD_SLEEP      = 2'h2,
    FIELD_SOFT_RESET = 2'h3
  } mode_field_e;
endpackage

// file: verilog/operating_mode_state_machine.sv
// Operating-mode controller of the system basis chip
// Summary of operation
// - Init mode at power-up and soft reset
// - Stop mode keeps main regulator on
// - Sleep mode turns main regulator off
// - Wake or failure leads to restart, host reset
// - Restart exits to normal after reset delay
// - Critical failure enters fail-safe, regulator off
// - Fail-safe held until wake or heat clears
// - Development mode stops the watchdog counter
// - Development mode allows all six modes
// - Strap selects watchdog failure response
// - Host exchanges use 16-bit frames
// - Mode field selects mode, cleared in restart
// - Any frame in init goes to normal
// - No trigger in long window means restart in init, strap-selected response in normal and stop
// - Wake events in init are discarded
`timescale 1ns/10ps
`include "opmode_params.svh"
module operating_mode_state_machine #(
  parameter int LIN_COUNT  = 1,
  parameter int WAKE_COUNT = 1,
  parameter int unsigned LONG_WINDOW_CYCLES = `LONG_WINDOW_MS * 1000 * `CLK_MHZ
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  // Host serial port
  input  wire logic                  i_spi_sclk,
  input  wire logic                  i_spi_cs_n,
  input  wire logic                  i_spi_mosi,
  output logic                       o_spi_miso,
  // Wake sources
  input  wire logic                  i_can_wake,
  input  wire logic [LIN_COUNT-1:0]  i_lin_transceivers_wake,
  input  wire logic [WAKE_COUNT-1:0] i_wake_inputs,
  // Supervision
  input  wire logic                  i_main_regulator_uv,
  input  wire logic                  i_over_temp,
  // Straps
  input  wire logic                  i_test_strap_n,
  input  wire logic                  i_cfg_strap,
  // Mode outputs
  output logic                       o_main_regulator_output_en,
  output logic                       o_host_reset_n,
  output opmode_pkg::mode_state_e    o_mode,
  output logic                       o_dev_mode,
  output logic                       o_wd_fail_restart,
  output logic                       o_wd_running
);
  import opmode_pkg::*;

  localparam int IN_W  = 5 + LIN_COUNT + WAKE_COUNT;
  // Test strap idles high, so reset must not fake a development strap
  localparam logic [IN_W-1:0] SYNC_IDLE = {1'b0, 1'b1, {(IN_W-2){1'b0}}};
  localparam int WD_W  = $clog2(LONG_WINDOW_CYCLES + 1);
  localparam int RD_CYCLES = (`RESTART_DELAY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int RD_W  = $clog2(RD_CYCLES + 1);

  logic [IN_W-1:0] pin_meta;     // First synchroniser stage
  logic [IN_W-1:0] pin_sync;     // Second synchroniser stage
  logic            wake_any;     // Any wake source active
  logic            uv;           // Regulator undervoltage
  logic            ot;           // Over-temperature
  logic            test_n_s;     // Test strap level
  logic            cfg_s;        // Config strap level
  logic            frame_valid;  // Complete frame received
  logic [15:0]     frame_data;   // Received frame
  logic            mode_write;   // Mode frame received
  logic            wd_trigger;   // Watchdog frame received
  mode_field_e     wr_field;     // Field value carried by a frame
  mode_field_e     mode_field;   // Operating-mode field
  mode_state_e     state;        // Current mode
  mode_state_e     next_state;   // Next mode
  logic            dev_mode;     // Development mode latched
  logic            cfg_restart;  // Watchdog failure goes to restart
  logic            fs_by_ot;     // Fail-safe caused by heat
  logic [WD_W-1:0] wd_count;     // Watchdog window counter
  logic            wd_run;       // Watchdog counting allowed
  logic            wd_fail;      // Window ran out
  logic [RD_W-1:0] rd_count;     // Restart delay counter
  logic            rd_done;      // Restart delay elapsed
  logic [15:0]     status_word;  // Word returned to the host

  // Async inputs through two flip-flops
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_meta <= SYNC_IDLE;
      pin_sync <= SYNC_IDLE;
    end else begin
      pin_meta <= {i_cfg_strap, i_test_strap_n, i_over_temp, i_main_regulator_uv,
                   i_wake_inputs, i_lin_transceivers_wake, i_can_wake};
      pin_sync <= pin_meta;
    end
  end

  // Unpack the synchronised levels
  assign wake_any = |pin_sync[IN_W-5:0];
  assign uv       = pin_sync[IN_W-4];
  assign ot       = pin_sync[IN_W-3];
  assign test_n_s = pin_sync[IN_W-2];
  assign cfg_s    = pin_sync[IN_W-1];

  // Host frame receiver
  spi_frame_port u_spi (
    .i_clk         (i_clk),
    .i_sys_rst     (i_sys_rst),
    .i_spi_sclk    (i_spi_sclk),
    .i_spi_cs_n    (i_spi_cs_n),
    .i_spi_mosi    (i_spi_mosi),
    .o_spi_miso    (o_spi_miso),
    .i_status      (status_word),
    .o_frame_valid (frame_valid),
    .o_frame_data  (frame_data)
  );

  // Frame decode
  assign wr_field   = mode_field_e'(frame_data[`MODE_FIELD_MSB:`MODE_FIELD_LSB]);
  assign mode_write = frame_valid && frame_data[`WRITE_BIT]
                      && (frame_data[`ADDR_MSB:`ADDR_LSB] == `ADDR_MODE_CTRL);
  assign wd_trigger = frame_valid && frame_data[`WRITE_BIT]
                      && (frame_data[`ADDR_MSB:`ADDR_LSB] == `ADDR_WD_CTRL);
  assign status_word = {state, mode_field, dev_mode, cfg_restart, wd_run, 8'h00};

  // Straps followed while in init, held afterwards
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dev_mode    <= 1'b0;
      cfg_restart <= 1'b0;
    end else if (state == ST_INIT) begin
      dev_mode    <= ~test_n_s;
      cfg_restart <= cfg_s;
    end
  end

  // Operating-mode field
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_field <= mode_field_e'(`MODE_FIELD_RESET);
    end else if (state == ST_RESTART || state == ST_INIT) begin
      mode_field <= FIELD_NORMAL;
    end else if (mode_write && (state == ST_NORMAL || state == ST_STOP)) begin
      mode_field <= wr_field;
    end
  end

  // Watchdog window, stopped in development mode
  assign wd_run  = !dev_mode && (state == ST_INIT || state == ST_NORMAL
                   || state == ST_STOP);
  assign wd_fail = wd_run && !wd_trigger
                   && (wd_count == WD_W'(LONG_WINDOW_CYCLES - 1));
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wd_count <= '0;
    end else if (dev_mode) begin
      wd_count <= wd_count;
    end else if (!wd_run || wd_trigger || wd_fail) begin
      wd_count <= '0;
    end else begin
      wd_count <= wd_count + WD_W'(1);
    end
  end

  // Restart delay, restarted while the failure persists
  assign rd_done = (rd_count == RD_W'(RD_CYCLES - 1));
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_count <= '0;
    end else if (state != ST_RESTART || uv) begin
      rd_count <= '0;
    end else if (!rd_done) begin
      rd_count <= rd_count + RD_W'(1);
    end
  end

  // Mode transitions
  always_comb begin
    next_state = state;
    case (state)
      // Wake events are not looked at here
      ST_INIT: begin
        if (ot) begin
          next_state = ST_FAILSAFE;
        end else if (wd_fail) begin
          next_state = ST_RESTART;
        end else if (frame_valid) begin
          next_state = ST_NORMAL;
        end
      end
      // Host controlled modes, same in development mode
      ST_NORMAL, ST_STOP: begin
        if (ot) begin
          next_state = ST_FAILSAFE;
        end else if (wd_fail) begin
          next_state = cfg_restart ? ST_RESTART : ST_FAILSAFE;
        end else if (uv) begin
          next_state = ST_RESTART;
        end else if (mode_write) begin
          case (wr_field)
            FIELD_NORMAL: next_state = ST_NORMAL;
            FIELD_STOP:   next_state = ST_STOP;
            FIELD_SLEEP:  next_state = ST_SLEEP;
            default:      next_state = ST_INIT;
          endcase
        end
      end
      // Leave sleep on wake only
      ST_SLEEP: begin
        if (wake_any) begin
          next_state = ST_RESTART;
        end
      end
      // Hold host in reset until delay done
      ST_RESTART: begin
        if (ot) begin
          next_state = ST_FAILSAFE;
        end else if (rd_done && !uv) begin
          next_state = ST_NORMAL;
        end
      end
      // Stay until wake or heat cleared
      ST_FAILSAFE: begin
        if (wake_any || (fs_by_ot && !ot)) begin
          next_state = ST_RESTART;
        end
      end
      default: begin
        next_state = ST_INIT;
      end
    endcase
  end

  // Mode register, init after reset
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= ST_INIT;
    end else begin
      state <= next_state;
    end
  end

  // Remember why fail-safe was entered
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fs_by_ot <= 1'b0;
    end else if (state != ST_FAILSAFE && next_state == ST_FAILSAFE) begin
      fs_by_ot <= ot;
    end
  end

  // Regulator enable and host reset from the coming mode
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_main_regulator_output_en <= 1'b1;
      o_host_reset_n             <= 1'b1;
    end else begin
      o_main_regulator_output_en <= (next_state != ST_SLEEP)
                                    && (next_state != ST_FAILSAFE);
      o_host_reset_n <= (next_state != ST_RESTART)
                        && (next_state != ST_FAILSAFE);
    end
  end

  // Status outputs
  assign o_mode            = state;
  assign o_dev_mode        = dev_mode;
  assign o_wd_fail_restart = cfg_restart;
  assign o_wd_running      = wd_run;

  AST_SOFT_RESET: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_NORMAL && mode_write && wr_field == FIELD_SOFT_RESET && !ot && !wd_fail && !uv
    |=> state == ST_INIT)
    else $error("soft reset did not reach init");
  AST_STOP_REG_ON: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_STOP |-> o_main_regulator_output_en)
    else $error("regulator off in stop");
  AST_SLEEP_REG_OFF: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_SLEEP |-> !o_main_regulator_output_en)
    else $error("regulator on in sleep");
  AST_SLEEP_WAKE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_SLEEP && wake_any |=> state == ST_RESTART ##0 !o_host_reset_n)
    else $error("wake in sleep did not restart");
  AST_RESTART_EXIT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_RESTART && rd_done && !uv && !ot |=> state == ST_NORMAL ##0 o_host_reset_n)
    else $error("restart did not exit after delay");
  AST_RESTART_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_RESTART && uv |=> state != ST_NORMAL ##1 state != ST_NORMAL)
    else $error("restart left while failure present");
  AST_WD_FAILSAFE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_NORMAL && wd_fail && !cfg_restart |=> state == ST_FAILSAFE
    ##0 !o_main_regulator_output_en)
    else $error("critical failure did not reach fail-safe");
  AST_FS_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_FAILSAFE && !wake_any && !(fs_by_ot && !ot) |=> state == ST_FAILSAFE)
    else $error("fail-safe left without cause");
  AST_DEV_WD_STOP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    dev_mode && $past(dev_mode) |-> $stable(wd_count) && !wd_fail)
    else $error("watchdog ran in development mode");
  AST_DEV_SLEEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    dev_mode && state == ST_NORMAL && mode_write && wr_field == FIELD_SLEEP && !ot && !uv
    |=> state == ST_SLEEP)
    else $error("mode refused in development mode");
  AST_WD_CFG: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_STOP && wd_fail && cfg_restart && !ot |=> state == ST_RESTART)
    else $error("strap response to watchdog failure wrong");
  AST_FIELD_CLEAR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_RESTART ##1 state == ST_RESTART |-> mode_field == FIELD_NORMAL)
    else $error("mode field not cleared in restart");
  AST_INIT_FRAME: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_INIT && frame_valid && !wd_fail && !ot |=> state == ST_NORMAL)
    else $error("frame in init did not reach normal");
  AST_INIT_WD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_INIT && wd_fail && !ot |=> state == ST_RESTART)
    else $error("missing trigger in init not handled");
  AST_INIT_WAKE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    state == ST_INIT && wake_any && !frame_valid && !wd_fail && !ot |=> state == ST_INIT)
    else $error("wake event acted on in init");
endmodule

// file: verilog/spi_frame_port.sv
// Serial slave port that receives and answers 16-bit frames
`timescale 1ns/10ps
`include "opmode_params.svh"
module spi_frame_port (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Serial pins
  input  wire logic        i_spi_sclk,
  input  wire logic        i_spi_cs_n,
  input  wire logic        i_spi_mosi,
  output logic             o_spi_miso,
  // Status word shifted out
  input  wire logic [15:0] i_status,
  // Received frame
  output logic             o_frame_valid,
  output logic [15:0]      o_frame_data
);
  logic [2:0]  sclk_q;     // Synchroniser plus edge history
  logic [2:0]  cs_q;       // Synchroniser plus edge history
  logic [1:0]  mosi_q;     // Synchroniser
  logic [15:0] shift_in;   // Incoming bits
  logic [15:0] shift_out;  // Outgoing bits
  logic [4:0]  bit_count;  // Bits seen, saturating
  logic        sclk_rise;  // Sampling edge
  logic        sclk_fall;  // Launch edge
  logic        cs_fall;    // Frame start
  logic        cs_rise;    // Frame end
  logic        selected;   // Frame in progress

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign cs_fall   = ~cs_q[1] & cs_q[2];
  assign cs_rise   = cs_q[1] & ~cs_q[2];
  assign selected  = ~cs_q[1];
  assign o_spi_miso = shift_out[15];

  // Pin synchronisers
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sclk_q <= 3'h0;
      cs_q   <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], i_spi_sclk};
      cs_q   <= {cs_q[1:0], i_spi_cs_n};
      mosi_q <= {mosi_q[0], i_spi_mosi};
    end
  end

  // Receive shifter and bit counter
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_in  <= 16'h0000;
      bit_count <= 5'h00;
    end else if (cs_fall) begin
      bit_count <= 5'h00;
    end else if (selected && sclk_rise) begin
      shift_in <= {shift_in[14:0], mosi_q[1]};
      if (bit_count != 5'h1f) begin
        bit_count <= bit_count + 5'h01;
      end
    end
  end

  // Frame delivery, only exact 16-bit frames
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_frame_valid <= 1'b0;
      o_frame_data  <= 16'h0000;
    end else begin
      o_frame_valid <= cs_rise && (bit_count == 5'(`FRAME_BITS));
      if (cs_rise) begin
        o_frame_data <= shift_in;
      end
    end
  end

  // Transmit shifter, MSB first
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      shift_out <= 16'h0000;
    end else if (cs_fall) begin
      shift_out <= i_status;
    end else if (selected && sclk_fall) begin
      shift_out <= {shift_out[14:0], 1'b0};
    end
  end

  // A frame is delivered only just after chip select ends
  AST_FRAME_AT_END: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_frame_valid |-> cs_q[2] && !$past(cs_q[2]))
    else $error("frame delivered outside frame end");
endmodule
